//--- hw/pfb_access.sv
// Host register file, plane steering and display counter hold of the planar frame buffer logic.
//
// How it works
// [RULE_01] Four-plane interleave: address bits pick plane.
// [RULE_02] Byte-pair bit affects writes only, without interleave.
// [RULE_03] Byte-pair 0: odd/even planes; 1: mask planes.
// [RULE_04] Extended bit off limits access to 64KB.
// [RULE_05] Font table select honoured only with extended.
// [RULE_06] Counter-hold write zeroes character counter until release.
// [RULE_07] Line counter advances from horizontal display enable.
// [RULE_08] Host uses sequencer index then data port.
// [RULE_09] Data port access goes to indexed register.
// [RULE_10] Graphics index resets to zero, nine registers.
// [RULE_11] Mode 0 enabled planes get set/reset copies.
// [RULE_12] Mode 3 rotated data ANDed mask, set/reset colour.
// [RULE_13] Enable bits act only in write mode 0.
// [RULE_14] Read mode 1 returns colour compare result.
// [RULE_15] Function field combines data with read latch.
// [RULE_16] Write data rotated right by rotate count.
// [RULE_17] Plane write mask gates plane writes always.
// [RULE_18] Read mode 0 returns selected plane byte.
// [RULE_19] Order: rotate, set/reset, function, masks.
`timescale 1ns/1ps
module pfb_access #(
   parameter int H_TOTAL = 100,
   parameter int H_DISPLAY = 80
) (
   // Clock and control
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Host I/O and memory cycles
   input wire pfb_pkg::pfb_io_req_t i_io,
   input wire pfb_pkg::pfb_mem_req_t i_mem,
   output logic [7:0] o_io_rdata,
   output logic [7:0] o_mem_rdata,
   output logic o_mem_ack,
   // Plane memory
   output pfb_pkg::pfb_plane_req_t o_plane,
   input wire logic [31:0] i_plane_rdata,
   // Display
   output logic [2:0] o_font_a,
   output logic [2:0] o_font_b,
   output logic [7:0] o_char_count,
   output logic [9:0] o_line_count
);
   import pfb_pkg::*;

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic [2:0] seq_idx_q, seq_idx_d;
   logic [3:0] gfx_idx_q, gfx_idx_d;
   logic [7:0] seq_q [0:7];
   logic [7:0] seq_d [0:7];
   logic [7:0] gfx_q [0:8];
   logic [7:0] gfx_d [0:8];
   logic hold_q, hold_d;
   logic [7:0] io_rdata_q, io_rdata_d;

   function automatic logic [7:0] seq_reset(input int i);
      return (i == PFB_SEQ_PLANE_WRITE_MASK) ? {4'h0, PFB_PLANE_MASK_RESET} : PFB_RESET_BYTE;
   endfunction : seq_reset

   always_comb begin
      seq_idx_d = seq_idx_q;
      gfx_idx_d = gfx_idx_q;
      seq_d = seq_q;
      gfx_d = gfx_q;
      hold_d = hold_q;
      io_rdata_d = io_rdata_q;
      if (i_io.wr) begin
         unique case (i_io.port)
            PFB_PORT_SEQ_INDEX: seq_idx_d = i_io.data[2:0];
            PFB_PORT_GFX_INDEX: gfx_idx_d = i_io.data[3:0]; // [RULE_10]
            PFB_PORT_SEQ_DATA: begin
               seq_d[seq_idx_q] = i_io.data; // [RULE_08]
               hold_d = (seq_idx_q == PFB_SEQ_CHAR_COUNTER_HOLD); // [RULE_06]
            end
            PFB_PORT_GFX_DATA: begin
               if (gfx_idx_q <= PFB_GFX_BIT_WRITE_MASK) begin
                  gfx_d[gfx_idx_q] = i_io.data; // [RULE_09]
               end
            end
            default: ;
         endcase
      end
      if (i_io.rd) begin
         unique case (i_io.port)
            PFB_PORT_SEQ_INDEX: io_rdata_d = {5'h00, seq_idx_q};
            PFB_PORT_GFX_INDEX: io_rdata_d = {4'h0, gfx_idx_q};
            PFB_PORT_SEQ_DATA: io_rdata_d = seq_q[seq_idx_q];
            PFB_PORT_GFX_DATA: io_rdata_d = (gfx_idx_q <= PFB_GFX_BIT_WRITE_MASK) ?
               gfx_q[gfx_idx_q] : 8'h00; // [RULE_09]
            default: io_rdata_d = 8'hff;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         seq_idx_q <= 3'h0;
         gfx_idx_q <= PFB_GFX_INDEX_RESET; // [RULE_10]
         for (int i = 0; i < 8; i++) begin
            seq_q[i] <= seq_reset(i);
         end
         for (int i = 0; i < 9; i++) begin
            gfx_q[i] <= (i == PFB_GFX_BIT_WRITE_MASK) ? PFB_BIT_MASK_RESET : PFB_RESET_BYTE;
         end
         hold_q <= 1'b0;
         io_rdata_q <= PFB_RESET_BYTE;
      end else if (i_ce) begin
         seq_idx_q <= seq_idx_d;
         gfx_idx_q <= gfx_idx_d;
         seq_q <= seq_d;
         gfx_q <= gfx_d;
         hold_q <= hold_d;
         io_rdata_q <= io_rdata_d;
      end
   end
   assign o_io_rdata = io_rdata_q;

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   logic [7:0] mm;
   logic four_plane, byte_pair, ext_mem;
   logic [3:0] plane_mask;
   logic [7:0] gmode;
   assign mm = seq_q[PFB_SEQ_MEMORY_MAPPING_MODE];
   assign four_plane = mm[PFB_MM_FOUR_PLANE_BIT];
   assign byte_pair = mm[PFB_MM_BYTE_PAIR_BIT];
   assign ext_mem = mm[PFB_MM_EXT_BIT];
   assign plane_mask = seq_q[PFB_SEQ_PLANE_WRITE_MASK][3:0];
   assign gmode = gfx_q[PFB_GFX_GRAPHICS_MODE_CONTROL];

   // Plane enables for a CPU cycle; reads ignore the byte-pair bit.
   function automatic logic [3:0] plane_sel(input logic [17:0] a, input logic is_wr);
      logic [3:0] s;
      s = 4'hf;
      if (four_plane) begin
         s = 4'h1 << a[1:0]; // [RULE_01]
      end else if (is_wr && !byte_pair) begin
         s = a[0] ? 4'ha : 4'h5; // [RULE_02] [RULE_03]
      end
      return s;
   endfunction : plane_sel

   function automatic logic [15:0] plane_addr(input logic [17:0] a);
      logic [17:0] r;
      r = a;
      if (four_plane) begin
         r = a >> 2;
      end
      return r[15:0];
   endfunction : plane_addr

   // ------------------------------------------------------------------
   // Frame buffer access
   // ------------------------------------------------------------------
   logic [31:0] latch_q, latch_d;
   pfb_plane_req_t plane_q, plane_d;
   logic rd_pend_q, rd_pend_d;
   logic [1:0] rd_plane_q, rd_plane_d;
   logic ack_q, ack_d;
   logic [7:0] mem_rdata_q, mem_rdata_d;
   logic [31:0] wp_data;
   logic [7:0] wp_mask;
   logic [7:0] wp_cmp;
   logic in_range;

   pfb_write_path u_write_path (
      .i_write_mode(gmode[1:0]),
      .i_sr_value(gfx_q[PFB_GFX_SET_RESET_VALUE][3:0]),
      .i_sr_enable(gfx_q[PFB_GFX_SET_RESET_ENABLE][3:0]),
      .i_rotate(gfx_q[PFB_GFX_ROTATE_AND_FUNCTION][2:0]),
      .i_func(gfx_q[PFB_GFX_ROTATE_AND_FUNCTION][PFB_RF_FUNC_LSB +: 2]),
      .i_bit_mask(gfx_q[PFB_GFX_BIT_WRITE_MASK]),
      .i_cmp_value(gfx_q[PFB_GFX_COLOUR_COMPARE_VALUE][3:0]),
      .i_cmp_care(gfx_q[PFB_GFX_COMPARE_IGNORE_MASK][3:0]),
      .i_cpu_data(i_mem.data),
      .i_latch(latch_q),
      .i_planes(i_plane_rdata),
      .o_wr_data(wp_data),
      .o_wr_mask(wp_mask),
      .o_cmp_result(wp_cmp)
   );

   // Without the extended bit only the first 64KB answers; writes above are dropped,
   // reads above return all ones.
   assign in_range = ext_mem || (plane_addr(i_mem.addr) == i_mem.addr[15:0] &&
      i_mem.addr[17:16] == 2'b00 && !four_plane) || (four_plane && i_mem.addr[17:16] == 2'b00); // [RULE_04]

   always_comb begin
      plane_d = '0;
      latch_d = latch_q;
      rd_pend_d = 1'b0;
      rd_plane_d = rd_plane_q;
      ack_d = 1'b0;
      mem_rdata_d = mem_rdata_q;
      if (i_mem.wr) begin
         ack_d = 1'b1;
         if (in_range) begin
            plane_d.wr = 1'b1;
            plane_d.addr = plane_addr(i_mem.addr);
            plane_d.plane_en = plane_sel(i_mem.addr, 1'b1) & plane_mask; // [RULE_17]
            plane_d.data = wp_data; // [RULE_19]
            plane_d.bit_mask = wp_mask;
         end
      end else if (i_mem.rd) begin
         if (in_range) begin
            plane_d.rd = 1'b1;
            plane_d.addr = plane_addr(i_mem.addr);
            plane_d.plane_en = plane_sel(i_mem.addr, 1'b0);
            rd_pend_d = 1'b1;
            rd_plane_d = four_plane ? i_mem.addr[1:0] :
               gfx_q[PFB_GFX_READ_PLANE_CHOICE][1:0]; // [RULE_18] [RULE_01]
         end else begin
            ack_d = 1'b1;
            mem_rdata_d = 8'hff; // [RULE_04]
         end
      end
      if (rd_pend_q) begin
         latch_d = i_plane_rdata;
         ack_d = 1'b1;
         mem_rdata_d = gmode[PFB_GM_READ_MODE_BIT] ? wp_cmp : // [RULE_14]
            i_plane_rdata[rd_plane_q*8 +: 8]; // [RULE_18]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         plane_q <= '0;
         latch_q <= 32'h0000_0000;
         rd_pend_q <= 1'b0;
         rd_plane_q <= 2'h0;
         ack_q <= 1'b0;
         mem_rdata_q <= PFB_RESET_BYTE;
      end else if (i_ce) begin
         plane_q <= plane_d;
         latch_q <= latch_d;
         rd_pend_q <= rd_pend_d;
         rd_plane_q <= rd_plane_d;
         ack_q <= ack_d;
         mem_rdata_q <= mem_rdata_d;
      end
   end
   assign o_plane = plane_q;
   assign o_mem_ack = ack_q;
   assign o_mem_rdata = mem_rdata_q;

   // ------------------------------------------------------------------
   // Display counters and font select
   // ------------------------------------------------------------------
   logic [7:0] hcnt_q, hcnt_d;
   logic [9:0] vcnt_q, vcnt_d;
   logic [2:0] font_a_q, font_a_d, font_b_q, font_b_d;
   logic [7:0] fts;

   assign fts = seq_q[PFB_SEQ_FONT_TABLE_SELECT];

   always_comb begin
      hcnt_d = hcnt_q;
      vcnt_d = vcnt_q;
      if (hold_q) begin
         hcnt_d = 8'h00; // [RULE_06]
      end else if (hcnt_q == 8'(H_TOTAL - 1)) begin
         hcnt_d = 8'h00;
      end else begin
         hcnt_d = hcnt_q + 8'h01;
      end
      // Line advance comes from the end of display enable, which a hold suppresses.
      if (!hold_q && hcnt_q == 8'(H_DISPLAY - 1)) begin
         vcnt_d = vcnt_q + 10'h001; // [RULE_07]
      end
      // Without extended memory only tables 0 and 1 remain reachable.
      font_a_d = ext_mem ? {fts[1:0], fts[4]} : {2'b00, fts[4]}; // [RULE_05]
      font_b_d = ext_mem ? {fts[3:2], fts[5]} : {2'b00, fts[5]}; // [RULE_05]
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         hcnt_q <= 8'h00;
         vcnt_q <= 10'h000;
         font_a_q <= 3'h0;
         font_b_q <= 3'h0;
      end else if (i_ce) begin
         hcnt_q <= hcnt_d;
         vcnt_q <= vcnt_d;
         font_a_q <= font_a_d;
         font_b_q <= font_b_d;
      end
   end
   assign o_char_count = hcnt_q;
   assign o_line_count = vcnt_q;
   assign o_font_a = font_a_q;
   assign o_font_b = font_b_q;

endmodule : pfb_access

//--- include/pfb_pkg.sv
// Package with register map, field positions and carrier types of the planar frame buffer logic.
package pfb_pkg;

   // ------------------------------------------------------------------
   // I/O ports and register indices
   // ------------------------------------------------------------------
   localparam logic [15:0] PFB_PORT_SEQ_INDEX = 16'h03c4;
   localparam logic [15:0] PFB_PORT_SEQ_DATA = 16'h03c5;
   localparam logic [15:0] PFB_PORT_GFX_INDEX = 16'h03ce;
   localparam logic [15:0] PFB_PORT_GFX_DATA = 16'h03cf;

   localparam logic [2:0] PFB_SEQ_PLANE_WRITE_MASK = 3'h2;
   localparam logic [2:0] PFB_SEQ_FONT_TABLE_SELECT = 3'h3;
   localparam logic [2:0] PFB_SEQ_MEMORY_MAPPING_MODE = 3'h4;
   localparam logic [2:0] PFB_SEQ_CHAR_COUNTER_HOLD = 3'h7;

   localparam logic [3:0] PFB_GFX_SET_RESET_VALUE = 4'h0;
   localparam logic [3:0] PFB_GFX_SET_RESET_ENABLE = 4'h1;
   localparam logic [3:0] PFB_GFX_COLOUR_COMPARE_VALUE = 4'h2;
   localparam logic [3:0] PFB_GFX_ROTATE_AND_FUNCTION = 4'h3;
   localparam logic [3:0] PFB_GFX_READ_PLANE_CHOICE = 4'h4;
   localparam logic [3:0] PFB_GFX_GRAPHICS_MODE_CONTROL = 4'h5;
   localparam logic [3:0] PFB_GFX_MISC = 4'h6;
   localparam logic [3:0] PFB_GFX_COMPARE_IGNORE_MASK = 4'h7;
   localparam logic [3:0] PFB_GFX_BIT_WRITE_MASK = 4'h8;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int PFB_MM_EXT_BIT = 1;
   localparam int PFB_MM_BYTE_PAIR_BIT = 2;
   localparam int PFB_MM_FOUR_PLANE_BIT = 3;
   localparam int PFB_RF_FUNC_LSB = 3;
   localparam int PFB_GM_READ_MODE_BIT = 3;

   // ------------------------------------------------------------------
   // Reset values and sizes
   // ------------------------------------------------------------------
   localparam logic [7:0] PFB_RESET_BYTE = 8'h00;
   localparam logic [3:0] PFB_GFX_INDEX_RESET = 4'h0;
   localparam logic [3:0] PFB_PLANE_MASK_RESET = 4'hf;
   localparam logic [7:0] PFB_BIT_MASK_RESET = 8'hff;
   localparam int PFB_ADDR_W = 16;
   localparam int PFB_CHAR_CNT_W = 8;
   localparam int PFB_LINE_CNT_W = 10;

   typedef enum logic [1:0] {
      PFB_FN_PASS = 2'b00,
      PFB_FN_AND = 2'b01,
      PFB_FN_OR = 2'b10,
      PFB_FN_XOR = 2'b11
   } pfb_func_t;

   // Host I/O cycle toward the index/data ports.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] port;
      logic [7:0] data;
   } pfb_io_req_t;

   // Host frame buffer cycle.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [17:0] addr;
      logic [7:0] data;
   } pfb_mem_req_t;

   // Per-plane memory access toward the plane arrays.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [3:0] plane_en;
      logic [31:0] data;
      logic [7:0] bit_mask;
   } pfb_plane_req_t;

endpackage : pfb_pkg

//--- hw/pfb_write_path.sv
// Combinational write datapath and colour compare of the planar frame buffer logic.
`timescale 1ns/1ps
module pfb_write_path (
   // Configuration
   input wire logic [1:0] i_write_mode,
   input wire logic [3:0] i_sr_value,
   input wire logic [3:0] i_sr_enable,
   input wire logic [2:0] i_rotate,
   input wire logic [1:0] i_func,
   input wire logic [7:0] i_bit_mask,
   input wire logic [3:0] i_cmp_value,
   input wire logic [3:0] i_cmp_care,
   // Data
   input wire logic [7:0] i_cpu_data,
   input wire logic [31:0] i_latch,
   input wire logic [31:0] i_planes,
   output logic [31:0] o_wr_data,
   output logic [7:0] o_wr_mask,
   output logic [7:0] o_cmp_result
);
   import pfb_pkg::*;

   function automatic logic [7:0] rotr(input logic [7:0] v, input logic [2:0] n);
      logic [15:0] dbl;
      dbl = {v, v} >> n;
      return dbl[7:0];
   endfunction : rotr

   logic [7:0] rot;
   logic [7:0] src;
   logic [7:0] lat;

   always_comb begin
      rot = rotr(i_cpu_data, i_rotate); // [RULE_16] [RULE_19]
      o_wr_mask = i_bit_mask;
      o_wr_data = '0;
      if (i_write_mode == 2'h3) begin
         o_wr_mask = rot & i_bit_mask; // [RULE_12]
      end
      for (int p = 0; p < 4; p++) begin
         src = rot;
         lat = i_latch[p*8 +: 8];
         if (i_write_mode == 2'h3) begin
            src = {8{i_sr_value[p]}}; // [RULE_12]
         end else if (i_write_mode == 2'h0 && i_sr_enable[p]) begin
            src = {8{i_sr_value[p]}}; // [RULE_11] [RULE_13]
         end
         unique case (pfb_func_t'(i_func)) // [RULE_15]
            PFB_FN_PASS: o_wr_data[p*8 +: 8] = src;
            PFB_FN_AND: o_wr_data[p*8 +: 8] = src & lat;
            PFB_FN_OR: o_wr_data[p*8 +: 8] = src | lat;
            PFB_FN_XOR: o_wr_data[p*8 +: 8] = src ^ lat;
         endcase
      end
      o_cmp_result = 8'hff;
      for (int p = 0; p < 4; p++) begin
         if (i_cmp_care[p]) begin
            o_cmp_result = o_cmp_result & ~(i_planes[p*8 +: 8] ^ {8{i_cmp_value[p]}}); // [RULE_14]
         end
      end
   end

endmodule : pfb_write_path

//--- test/pfb_plane_mem.sv
// Behavioural four-plane memory that answers the plane requests of the access logic.
`timescale 1ns/1ps
module pfb_plane_mem
   import pfb_pkg::*;
(
   // Plane request and read data
   input wire logic i_mclk,
   input wire pfb_pkg::pfb_plane_req_t i_req,
   output logic [31:0] o_rdata
);
   logic [7:0] mem [4][256];
   logic [7:0] a;
   assign a = i_req.addr[7:0];
   initial begin
      for (int p = 0; p < 4; p++) begin
         for (int k = 0; k < 256; k++) begin
            mem[p][k] = 8'h00;
         end
      end
   end
   // The access logic takes read data in the same cycle as its plane read, so the bytes
   // answer at once; outside a read they are inverted so stale bytes never pass for fresh.
   assign o_rdata = i_req.rd ? {mem[3][a], mem[2][a], mem[1][a], mem[0][a]} :
      ~{mem[3][a], mem[2][a], mem[1][a], mem[0][a]};
   always @(posedge i_mclk) begin
      for (int p = 0; p < 4; p++) begin
         if (i_req.wr && i_req.plane_en[p]) begin
            mem[p][a] <= (mem[p][a] & ~i_req.bit_mask) | (i_req.data[p*8 +: 8] & i_req.bit_mask);
         end
      end
   end
endmodule : pfb_plane_mem

//--- test/pfb_access_chk.sv
// Port checker of the planar frame buffer access logic.
`timescale 1ns/1ps
module pfb_access_chk
   import pfb_pkg::*;
(
   // Watched ports
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire pfb_pkg::pfb_io_req_t i_io,
   input wire pfb_pkg::pfb_mem_req_t i_mem,
   input wire logic [7:0] o_io_rdata,
   input wire logic o_mem_ack,
   input wire pfb_pkg::pfb_plane_req_t o_plane,
   input wire logic [2:0] o_font_a,
   input wire logic [2:0] o_font_b,
   input wire logic [7:0] o_char_count,
   input wire logic [9:0] o_line_count
);
   logic [2:0] sidx_q, sidx_d;
   logic [7:0] mm_q, mm_d;
   logic hold_q, hold_d;
   logic sw;
   // Shadow of the sequencer state, rebuilt from the host cycles alone.
   always_comb begin
      sw = i_ce && i_io.wr && i_io.port == PFB_PORT_SEQ_DATA;
      sidx_d = sidx_q;
      mm_d = mm_q;
      hold_d = hold_q;
      if (i_ce && i_io.wr && i_io.port == PFB_PORT_SEQ_INDEX) begin
         sidx_d = i_io.data[2:0];
      end
      if (sw) begin
         hold_d = (sidx_q == PFB_SEQ_CHAR_COUNTER_HOLD);
      end
      if (sw && sidx_q == PFB_SEQ_MEMORY_MAPPING_MODE) begin
         mm_d = i_io.data;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         sidx_q <= 3'h0;
         mm_q <= 8'h00;
         hold_q <= 1'b0;
      end else begin
         sidx_q <= sidx_d;
         mm_q <= mm_d;
         hold_q <= hold_d;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   AST_CHAIN4: assert property (mm_q[3] && i_mem.wr |=> !o_plane.wr ||
      ((o_plane.plane_en & ~(4'h1 << $past(i_mem.addr[1:0]))) == 4'h0
      && o_plane.addr == $past(i_mem.addr[17:2])))
      else $error("four-plane write reached a wrong plane");
   AST_ODD_EVEN: assert property (!mm_q[3] && !mm_q[2] && i_mem.wr |=>
      (o_plane.plane_en & ($past(i_mem.addr[0]) ? 4'h5 : 4'ha)) == 4'h0)
      else $error("odd/even write reached a wrong plane");
   AST_RD_ONLY: assert property (i_mem.rd && !i_mem.wr |=> !o_plane.wr)
      else $error("read produced a plane write");
   AST_RD_ACK: assert property (o_plane.rd |=> o_mem_ack)
      else $error("read not answered after plane read");
   AST_WR_ACK: assert property (o_plane.wr |-> o_mem_ack)
      else $error("plane write without acknowledge");
   AST_HOLD: assert property (hold_q && $past(hold_q) |-> o_char_count == 8'h00)
      else $error("character counter moved while held");
   AST_LINE: assert property (hold_q && $past(hold_q) |=> $stable(o_line_count))
      else $error("line counter moved while held");
   AST_FONT: assert property (!mm_q[1] && !$past(mm_q[1]) |->
      o_font_a[2:1] == 2'b00 && o_font_b[2:1] == 2'b00)
      else $error("font table beyond first pair without extended memory");
   AST_IDX_TOP: assert property (i_io.rd && i_io.port == PFB_PORT_GFX_INDEX |=>
      o_io_rdata[7:4] == 4'h0)
      else $error("graphics index upper bits not zero");
endmodule : pfb_access_chk

bind pfb_access pfb_access_chk u_chk (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_io(i_io), .i_mem(i_mem),
   .o_io_rdata(o_io_rdata), .o_mem_ack(o_mem_ack), .o_plane(o_plane),
   .o_font_a(o_font_a), .o_font_b(o_font_b), .o_char_count(o_char_count),
   .o_line_count(o_line_count)
);

//--- test/pfb_access_tb.sv
// Self-checking testbench of the planar frame buffer access logic.
`timescale 1ns/1ps
module pfb_access_tb;
   import pfb_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   pfb_io_req_t io_drv = '0;
   pfb_mem_req_t mem_drv = '0;
   pfb_plane_req_t plane;
   logic [31:0] plane_rdata;
   logic [7:0] io_rdata, mem_rdata, char_cnt;
   logic [2:0] font_a, font_b;
   logic [9:0] line_cnt;
   logic mem_ack;
   int errors = 0;
   int samples_checked = 0;
   int wr_cnt = 0;
   logic ce = 1'b1;
   always #25 i_mclk = ~i_mclk;
   always @(posedge i_mclk) if (plane.wr) wr_cnt++;
   pfb_access DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .i_io(io_drv),
      .i_mem(mem_drv), .o_io_rdata(io_rdata), .o_mem_rdata(mem_rdata), .o_mem_ack(mem_ack),
      .o_plane(plane), .i_plane_rdata(plane_rdata), .o_font_a(font_a), .o_font_b(font_b),
      .o_char_count(char_cnt), .o_line_count(line_cnt));
   pfb_plane_mem mdl (.i_mclk(i_mclk), .i_req(plane), .o_rdata(plane_rdata));
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic io(input logic w, input logic [15:0] p, input logic [7:0] d);
      @(negedge i_mclk);
      io_drv = {w, !w, p, d};
      @(negedge i_mclk);
      io_drv = '0;
   endtask : io
   task automatic sr(input logic [7:0] i, input logic [7:0] d);
      io(1'b1, PFB_PORT_SEQ_INDEX, i);
      io(1'b1, PFB_PORT_SEQ_DATA, d);
   endtask : sr
   task automatic gr(input logic [7:0] i, input logic [7:0] d);
      io(1'b1, PFB_PORT_GFX_INDEX, i);
      io(1'b1, PFB_PORT_GFX_DATA, d);
   endtask : gr
   task automatic rdp(input logic [15:0] p, output logic [7:0] d);
      io(1'b0, p, 8'h00);
      @(negedge i_mclk);
      d = io_rdata;
   endtask : rdp
   // Every cycle acknowledges, a dropped write too, so a missing acknowledge is a mismatch.
   task automatic mem(input logic w, input logic [17:0] a, input logic [7:0] d,
         output logic [7:0] r);
      @(negedge i_mclk);
      mem_drv = {w, !w, a, d};
      @(negedge i_mclk);
      mem_drv = '0;
      for (int k = 0; k < 6 && mem_ack !== 1'b1; k++) @(negedge i_mclk);
      if (mem_ack !== 1'b1) begin
         errors++;
         $display("mismatch mem_ack expected 1 seen 0");
         close_out();
      end
      r = mem_rdata;
      @(negedge i_mclk);
   endtask : mem
   task automatic t_regs;
      logic [7:0] d;
      rdp(PFB_PORT_GFX_INDEX, d);
      chk("gfx_index_rst", 8'h00, d);
      io(1'b1, PFB_PORT_SEQ_INDEX, 8'h02);
      rdp(PFB_PORT_SEQ_DATA, d);
      chk("plane_mask_rst", 8'h0f, d);
      io(1'b1, PFB_PORT_GFX_INDEX, 8'hf9);
      rdp(PFB_PORT_GFX_INDEX, d);
      chk("gfx_index_top", 8'h09, d);
      rdp(PFB_PORT_GFX_DATA, d);
      chk("gfx_void", 8'h00, d);
      for (int i = 0; i < 4; i++) begin
         gr(i[7:0], 8'h0a + i[7:0]);
         rdp(PFB_PORT_GFX_DATA, d);
         chk("gfx_reg", 8'h0a + i[7:0], d);
      end
      $display("done regs");
   endtask : t_regs
   task automatic t_planes;
      logic [7:0] d;
      int n;
      gr(8'h01, 8'h00);
      gr(8'h03, 8'h00);
      sr(8'h04, 8'h0a);
      for (int i = 0; i < 4; i++) begin
         mem(1'b1, i[17:0], 8'h10 + i[7:0], d);
         chk("chain_plane", 8'h10 + i[7:0], mdl.mem[i][0]);
         mem(1'b0, i[17:0], 8'h00, d);
         chk("chain_read", 8'h10 + i[7:0], d);
      end
      sr(8'h02, 8'h04);
      sr(8'h04, 8'h06);
      mem(1'b1, 18'h5, 8'h3c, d);
      chk("seq_plane2", 8'h3c, mdl.mem[2][5]);
      chk("seq_plane0", 8'h00, mdl.mem[0][5]);
      sr(8'h04, 8'h02);
      mem(1'b1, 18'h40, 8'h11, d);
      mem(1'b1, 18'h41, 8'h22, d);
      chk("odd_even", 8'h11, mdl.mem[2][8'h40]);
      chk("odd_masked", 8'h00, mdl.mem[3][8'h41]);
      sr(8'h04, 8'h04);
      n = wr_cnt;
      mem(1'b1, 18'h10005, 8'h3c, d);
      chk("ext_drop", n[7:0], wr_cnt[7:0]);
      sr(8'h04, 8'h06);
      mem(1'b1, 18'h10005, 8'h3c, d);
      chk("ext_pass", n[7:0] + 8'h1, wr_cnt[7:0]);
      $display("done planes");
   endtask : t_planes
   task automatic t_datapath;
      logic [7:0] d, l, e;
      logic [7:0] ex [4];
      sr(8'h02, 8'h0f);
      gr(8'h03, 8'h01);
      mem(1'b1, 18'h30, 8'h01, d);
      chk("rotate", 8'h80, mdl.mem[0][8'h30]);
      mem(1'b0, 18'h5, 8'h00, d);
      for (int f = 0; f < 4; f++) begin
         gr(8'h03, {3'h0, f[1:0], 3'h0});
         mem(1'b1, 18'h8 + f[17:0], 8'h5a, d);
         for (int p = 0; p < 4; p++) begin
            l = (p == 2) ? 8'h3c : 8'h00;
            e = (f == 0) ? 8'h5a : (f == 1) ? (8'h5a & l) : (f == 2) ? (8'h5a | l) : (8'h5a ^ l);
            chk("function", e, mdl.mem[p][8 + f]);
         end
      end
      gr(8'h03, 8'h00);
      gr(8'h00, 8'h05);
      gr(8'h01, 8'h03);
      mem(1'b1, 18'h20, 8'ha5, d);
      ex = '{8'hff, 8'h00, 8'ha5, 8'ha5};
      for (int p = 0; p < 4; p++) chk("mode0", ex[p], mdl.mem[p][8'h20]);
      gr(8'h05, 8'h03);
      gr(8'h08, 8'hf0);
      mem(1'b1, 18'h20, 8'h3c, d);
      ex = '{8'hff, 8'h00, 8'hb5, 8'h85};
      for (int p = 0; p < 4; p++) chk("mode3", ex[p], mdl.mem[p][8'h20]);
      gr(8'h08, 8'hff);
      gr(8'h05, 8'h08);
      gr(8'h02, 8'h0b);
      ex = '{8'h0f, 8'h09, 8'h00, 8'h00};
      e = 8'h00;
      for (int c = 0; c < 3; c++) begin
         gr(8'h07, ex[c]);
         mem(1'b0, 18'h20, 8'h00, d);
         chk("compare", (c == 0) ? 8'h00 : (c == 1) ? 8'h85 : 8'hff, d);
      end
      gr(8'h05, 8'h00);
      gr(8'h04, 8'h02);
      mem(1'b0, 18'h20, 8'h00, d);
      chk("read_plane", 8'hb5, d);
      $display("done datapath");
   endtask : t_datapath
   task automatic t_display;
      logic [9:0] lc;
      ce = 1'b0;
      lc = {2'h0, char_cnt};
      repeat (20) @(negedge i_mclk);
      chk("ce_freeze", lc[7:0], char_cnt);
      ce = 1'b1;
      sr(8'h07, 8'h00);
      repeat (3) @(negedge i_mclk);
      lc = line_cnt;
      repeat (150) @(negedge i_mclk);
      chk("char_held", 8'h00, char_cnt);
      chk("line_held", lc[7:0], line_cnt[7:0]);
      sr(8'h03, 8'h16);
      repeat (5) @(negedge i_mclk);
      chk("char_run", 8'h01, {7'h0, char_cnt != 8'h00});
      lc = line_cnt;
      repeat (110) @(negedge i_mclk);
      chk("line_run", 8'h01, {7'h0, line_cnt != lc});
      sr(8'h04, 8'h04);
      repeat (2) @(negedge i_mclk);
      chk("font_a_base", 8'h01, {5'h0, font_a});
      chk("font_b_base", 8'h00, {5'h0, font_b});
      sr(8'h04, 8'h06);
      repeat (2) @(negedge i_mclk);
      chk("font_a_ext", 8'h05, {5'h0, font_a});
      chk("font_b_ext", 8'h02, {5'h0, font_b});
      $display("done display");
   endtask : t_display
   initial begin
      repeat (3) @(negedge i_mclk);
      i_rst_n = 1'b1;
      t_regs();
      t_planes();
      t_datapath();
      t_display();
      close_out();
   end
endmodule : pfb_access_tb
